// file: hw/asmc_pkg.sv
// package: constants for the serial mode control block
package asmc_pkg;
    localparam int WORD_BITS = 16;
    localparam int DATA_BITS = 12;
    localparam int SEL_BITS = 4;
    localparam logic [3:0] SEL_LONG_ENABLE = 4'h0;
    localparam logic [3:0] SEL_AUX_DAC_ONE = 4'h1;
    localparam logic [3:0] SEL_AUX_DAC_TWO = 4'h2;
    localparam logic [3:0] SEL_AUX_DAC_THREE = 4'h3;
    localparam logic [3:0] SEL_I_TRIM = 4'h4;
    localparam logic [3:0] SEL_Q_TRIM = 4'h5;
    localparam logic [3:0] SEL_CM_LEVEL = 4'h6;
    localparam logic [3:0] SEL_AUX_ADC = 4'h7;
    localparam logic [3:0] SEL_SHORT_ENABLE = 4'h8;
    // long enable word field positions
    localparam int POS_AUX_ADC_OFF = 9;
    localparam int POS_AUX_DAC_CH_ONE_OFF = 4;
    localparam int POS_AUX_DAC_CH_TWO_OFF = 5;
    localparam int POS_AUX_DAC_CH_THREE_OFF = 6;
    localparam int TRIM_BITS = 6;
    localparam int CM_BITS = 2;
    // power state codes (low four enable bits)
    localparam logic [3:0] CODE_FAST_RX_SLOW_TX = 4'h3;
    localparam logic [3:0] CODE_SLOW_RX_FAST_TX = 4'h4;
    localparam logic [3:0] CODE_SLOW_BOTH = 4'h5;
    localparam logic [3:0] CODE_FAST_BOTH = 4'h6;
    localparam logic [3:0] CODE_SPI_SLOW_RX = 4'hB;
    localparam logic [3:0] CODE_SPI_SLOW_TX = 4'hC;
    localparam logic [3:0] CODE_SPI_FAST_RX = 4'hD;
    localparam logic [3:0] CODE_SPI_FAST_TX = 4'hE;
    // reset values
    localparam logic [11:0] RST_LONG_ENABLE = 12'h004;
    localparam logic [11:0] RST_DATA = 12'h000;
    localparam logic [1:0] RST_CM = 2'h0;
endpackage : asmc_pkg

// file: hw/asmc_link_if.sv
// interface: received word strobe from the serial shifter
interface asmc_link_if;
    logic wordValid;
    logic [15:0] word;
    modport shifter (output wordValid, output word);
    modport decoder (input wordValid, input word);
endinterface : asmc_link_if

// file: hw/asmc_shifter.sv
// module: serial pin sampler and 16-bit word shifter
module asmc_shifter (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic serialClk,
    input wire logic serialSelN,
    input wire logic serialData,
    asmc_link_if.shifter link
);
    typedef struct packed {
        logic [1:0] clkSync;
        logic [1:0] selSync;
        logic [1:0] datSync;
        logic clkPrev;
        logic [15:0] shift;
        logic [4:0] count;
        logic valid;
    } asmc_shift_state_t;

    asmc_shift_state_t st_reg;
    asmc_shift_state_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.clkSync = {st_reg.clkSync[0], serialClk};
        st_next.selSync = {st_reg.selSync[0], serialSelN};
        st_next.datSync = {st_reg.datSync[0], serialData};
        st_next.clkPrev = st_reg.clkSync[1];
        st_next.valid = 1'b0;
        if (st_reg.selSync[1]) begin
            // word commits on select release only when complete (see R19)
            if (st_reg.count == 5'(asmc_pkg::WORD_BITS)) begin
                st_next.valid = 1'b1;
            end
            st_next.count = 5'h00;
        end else if (st_reg.clkSync[1] && !st_reg.clkPrev) begin
            // msb first, select bits last (see R1)
            st_next.shift = {st_reg.shift[14:0], st_reg.datSync[1]};
            if (st_reg.count != 5'h1F) begin
                st_next.count = st_reg.count + 5'h01;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st_reg <= '{clkSync: 2'h0, selSync: 2'h3, datSync: 2'h0, clkPrev: 1'b0,
                        shift: 16'h0000, count: 5'h00, valid: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign link.wordValid = st_reg.valid;
    assign link.word = st_reg.shift;

    a_commit_needs_release: assert property (@(posedge sys_clk) disable iff (!reset_n)
        st_reg.valid |-> $past(st_reg.selSync[1]) && $past(st_reg.count) == 5'h10) // see R19
        else $error("word committed without full word and release");
endmodule : asmc_shifter

// file: hw/asmc_mode_control.sv
// module: serial mode control decoder for the front end
// Summary of operation
// R1: 16-bit words, data MSB first, select last
// R2: serial port decodes in every power state
// R3: four-bit select field picks target register
// R4: long enable word defines default mode
// R5: host programs desired mode after power-up
// R6: shutdown code powers everything off
// R7: idle keeps clock, reference; converters off
// R8: standby keeps only reference; aux-DACs held
// R9: short word leaves aux-ADC power bit
// R10: pin low selects receive, high transmit
// R11: code 0011 fast receive, slow transmit; code keeps transmit on, receive follows pin
// R12: default variant slow receive, fast transmit; code keeps receive on, transmit follows pin
// R13: code 0101 slow switching both ways
// R14: fast-fast keeps both converters powered
// R15: aux-DAC words load twelve data bits
// R16: bits 4-6 switch off aux-DACs
// R17: aux-ADC power bit: zero on, one off
// R18: two bits choose DAC common mode
// R19: word takes effect after release only
// R20: registers persist until same select rewritten
module asmc_mode_control #(
    parameter int DATA_W = 12
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic serialClk,
    input wire logic serialSelN,
    input wire logic serialData,
    input wire logic txRxPin,
    output logic rxAdcOn,
    output logic txDacOn,
    output logic busDriveOut,
    output logic clockOn,
    output logic referenceOn,
    output logic auxAdcOn,
    output logic [2:0] auxDacOn,
    output logic [DATA_W-1:0] auxDacOneValue,
    output logic [DATA_W-1:0] auxDacTwoValue,
    output logic [DATA_W-1:0] auxDacThreeValue,
    output logic [5:0] txITrim,
    output logic [5:0] txQTrim,
    output logic [1:0] cmLevelSelect,
    output logic [DATA_W-1:0] auxAdcControl,
    output logic auxAdcStart
);
    typedef enum logic [2:0] {
        PWR_SHUTDOWN = 3'b000,
        PWR_IDLE = 3'b001,
        PWR_STANDBY = 3'b010,
        PWR_ACTIVE = 3'b011
    } asmc_power_t;

    typedef struct packed {
        logic [11:0] enable;
        logic [DATA_W-1:0] dacOne;
        logic [DATA_W-1:0] dacTwo;
        logic [DATA_W-1:0] dacThree;
        logic [5:0] iTrim;
        logic [5:0] qTrim;
        logic [1:0] cm;
        logic [DATA_W-1:0] adcCtl;
        logic adcStart;
        logic [1:0] pinSync;
        asmc_power_t power;
        logic rxAdc;
        logic txDac;
        logic busOut;
        logic clkOn;
        logic refOn;
        logic adcOn;
        logic [2:0] dacOn;
    } asmc_state_t;

    asmc_state_t st_reg;
    asmc_state_t st_next;
    asmc_link_if link ();

    asmc_shifter u_shifter (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .serialClk(serialClk),
        .serialSelN(serialSelN),
        .serialData(serialData),
        .link(link)
    );

    logic [11:0] payload;
    logic [3:0] sel;
    logic [3:0] code;
    logic pinTx;
    assign payload = link.word[15:4];
    assign sel = link.word[3:0];

    always_comb begin
        st_next = st_reg;
        st_next.adcStart = 1'b0;
        st_next.pinSync = {st_reg.pinSync[0], txRxPin};
        // decode accepted regardless of power state (see R2)
        if (link.wordValid) begin
            case (sel) // see R3
                asmc_pkg::SEL_LONG_ENABLE: begin
                    st_next.enable = payload; // see R16
                end
                asmc_pkg::SEL_SHORT_ENABLE: begin
                    st_next.enable = {st_reg.enable[11:4], payload[3:0]}; // see R9
                end
                asmc_pkg::SEL_AUX_DAC_ONE: begin
                    st_next.dacOne = payload[DATA_W-1:0]; // see R15
                end
                asmc_pkg::SEL_AUX_DAC_TWO: begin
                    st_next.dacTwo = payload[DATA_W-1:0]; // see R15
                end
                asmc_pkg::SEL_AUX_DAC_THREE: begin
                    st_next.dacThree = payload[DATA_W-1:0]; // see R15
                end
                asmc_pkg::SEL_I_TRIM: begin
                    st_next.iTrim = payload[5:0];
                end
                asmc_pkg::SEL_Q_TRIM: begin
                    st_next.qTrim = payload[5:0];
                end
                asmc_pkg::SEL_CM_LEVEL: begin
                    st_next.cm = payload[1:0]; // see R18
                end
                asmc_pkg::SEL_AUX_ADC: begin
                    st_next.adcCtl = payload[DATA_W-1:0];
                    st_next.adcStart = 1'b1;
                end
                default: begin
                    // unassigned selects are ignored; state persists (see R20)
                end
            endcase
        end

        code = st_next.enable[3:0];
        pinTx = st_reg.pinSync[1];
        st_next.adcOn = !st_next.enable[asmc_pkg::POS_AUX_ADC_OFF]; // see R17
        st_next.dacOn[0] = !st_next.enable[asmc_pkg::POS_AUX_DAC_CH_ONE_OFF]; // see R16
        st_next.dacOn[1] = !st_next.enable[asmc_pkg::POS_AUX_DAC_CH_TWO_OFF];
        st_next.dacOn[2] = !st_next.enable[asmc_pkg::POS_AUX_DAC_CH_THREE_OFF];
        st_next.clkOn = 1'b1;
        st_next.refOn = 1'b1;
        st_next.power = PWR_ACTIVE;
        st_next.rxAdc = 1'b1;
        st_next.txDac = 1'b1;
        st_next.busOut = !pinTx; // see R10
        if (code[2:0] == 3'b000 && st_next.enable[asmc_pkg::POS_AUX_ADC_OFF]) begin
            st_next.power = PWR_SHUTDOWN; // see R6
            st_next.rxAdc = 1'b0;
            st_next.txDac = 1'b0;
            st_next.dacOn = 3'b000;
            st_next.adcOn = 1'b0;
            st_next.clkOn = 1'b0;
            st_next.refOn = 1'b0;
            st_next.busOut = 1'b0;
        end else if (code[2:1] == 2'b00) begin
            st_next.power = PWR_IDLE; // see R7
            st_next.rxAdc = 1'b0;
            st_next.txDac = 1'b0;
            st_next.busOut = 1'b0;
        end else if (code[2:0] == 3'b010) begin
            st_next.power = PWR_STANDBY; // see R8
            st_next.rxAdc = 1'b0;
            st_next.txDac = 1'b0;
            st_next.adcOn = 1'b0;
            st_next.clkOn = 1'b0;
            st_next.busOut = 1'b0;
        end else begin
            case (code)
                asmc_pkg::CODE_FAST_RX_SLOW_TX: begin
                    st_next.rxAdc = !pinTx; // see R11
                end
                asmc_pkg::CODE_SLOW_BOTH: begin
                    st_next.rxAdc = !pinTx; // see R13
                    st_next.txDac = pinTx;
                end
                asmc_pkg::CODE_FAST_BOTH: begin
                    st_next.rxAdc = 1'b1; // see R14
                end
                asmc_pkg::CODE_SPI_SLOW_RX: begin
                    st_next.txDac = 1'b0;
                    st_next.busOut = 1'b1;
                end
                asmc_pkg::CODE_SPI_SLOW_TX: begin
                    st_next.rxAdc = 1'b0;
                    st_next.busOut = 1'b0;
                end
                asmc_pkg::CODE_SPI_FAST_RX: begin
                    st_next.busOut = 1'b1;
                end
                asmc_pkg::CODE_SPI_FAST_TX: begin
                    st_next.busOut = 1'b0;
                end
                default: begin
                    st_next.txDac = pinTx; // default variant (see R12)
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            // power-up: long enable word default variant (see R4)
            st_reg <= '{enable: asmc_pkg::RST_LONG_ENABLE, dacOne: '0, dacTwo: '0, dacThree: '0,
                        iTrim: 6'h00, qTrim: 6'h00, cm: asmc_pkg::RST_CM, adcCtl: '0,
                        adcStart: 1'b0, pinSync: 2'h0, power: PWR_ACTIVE, rxAdc: 1'b1,
                        txDac: 1'b0, busOut: 1'b1, clkOn: 1'b1, refOn: 1'b1, adcOn: 1'b1,
                        dacOn: 3'h7};
        end else begin
            st_reg <= st_next;
        end
    end

    assign rxAdcOn = st_reg.rxAdc;
    assign txDacOn = st_reg.txDac;
    assign busDriveOut = st_reg.busOut;
    assign clockOn = st_reg.clkOn;
    assign referenceOn = st_reg.refOn;
    assign auxAdcOn = st_reg.adcOn;
    assign auxDacOn = st_reg.dacOn;
    assign auxDacOneValue = st_reg.dacOne;
    assign auxDacTwoValue = st_reg.dacTwo;
    assign auxDacThreeValue = st_reg.dacThree;
    assign txITrim = st_reg.iTrim;
    assign txQTrim = st_reg.qTrim;
    assign cmLevelSelect = st_reg.cm;
    assign auxAdcControl = st_reg.adcCtl;
    assign auxAdcStart = st_reg.adcStart;

    sequence s_word(logic [3:0] s);
        link.wordValid && sel == s;
    endsequence

    a_shutdown_all_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
        st_reg.power == PWR_SHUTDOWN |-> !clockOn && !referenceOn && !auxAdcOn && auxDacOn == 3'h0) // see R6
        else $error("shutdown left a block powered");
    a_idle_clock_on: assert property (@(posedge sys_clk) disable iff (!reset_n)
        st_reg.power == PWR_IDLE |-> clockOn && referenceOn && !rxAdcOn && !txDacOn) // see R7
        else $error("idle power pattern wrong");
    a_standby_ref_only: assert property (@(posedge sys_clk) disable iff (!reset_n)
        st_reg.power == PWR_STANDBY |-> !clockOn && referenceOn && !auxAdcOn && !rxAdcOn) // see R8
        else $error("standby power pattern wrong");
    a_short_keeps_adc: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_word(asmc_pkg::SEL_SHORT_ENABLE) |=> st_reg.enable[9] == $past(st_reg.enable[9])) // see R9
        else $error("short word changed aux-adc bit");
    a_dac_one_load: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_word(asmc_pkg::SEL_AUX_DAC_ONE) |=> auxDacOneValue == $past(payload)) // see R15
        else $error("aux dac one not loaded");
    a_fast_both_on: assert property (@(posedge sys_clk) disable iff (!reset_n)
        st_reg.power == PWR_ACTIVE && st_reg.enable[3:0] == asmc_pkg::CODE_FAST_BOTH
        |-> rxAdcOn && txDacOn) // see R14
        else $error("fast both variant powered down a converter");
    a_cm_load: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_word(asmc_pkg::SEL_CM_LEVEL) |=> cmLevelSelect == $past(payload[1:0])) // see R18
        else $error("common mode not loaded");
    a_dac_persist: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !(link.wordValid && sel == asmc_pkg::SEL_AUX_DAC_TWO) |=> $stable(auxDacTwoValue)) // see R20
        else $error("aux dac two changed without its word");
endmodule : asmc_mode_control

// file: sim/asmc_host_model.sv
// host controller model driving the three-wire serial port
module asmc_host_model (
    output logic serialClk,
    output logic serialSelN,
    output logic serialData
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        serialClk = 1'b0;
        serialSelN = 1'b1;
        serialData = 1'b0;
    end

    // payload msb first, select field last; clock idles low between frames
    task automatic send_word(input logic [15:0] w, input int nbits);
        serialSelN = 1'b0;
        for (int i = 15; i > 15 - nbits; i--) begin
            serialData = w[i];
            #160 serialClk = 1'b1;
            #160 serialClk = 1'b0;
        end
        #160 serialSelN = 1'b1;
        // released data line shows no stale bit
        serialData = ~serialData;
        #400;
    endtask : send_word
endmodule : asmc_host_model

// file: sim/asmc_mode_control_tb_top.sv
// testbench top for the serial mode control block
module asmc_mode_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic sys_clk = 1'b0;
    logic reset_n;
    logic txRxPin;
    wire logic serialClk;
    wire logic serialSelN;
    wire logic serialData;
    wire logic rxAdcOn, txDacOn, busDriveOut, clockOn, referenceOn, auxAdcOn, auxAdcStart;
    wire logic [2:0] auxDacOn;
    wire logic [11:0] dacOne, dacTwo, dacThree, adcCtl;
    wire logic [5:0] iTrim, qTrim;
    wire logic [1:0] cmSel;
    wire logic [70:0] seenVec = {rxAdcOn, txDacOn, busDriveOut, clockOn, referenceOn, auxAdcOn,
        auxDacOn, dacOne, dacTwo, dacThree, iTrim, qTrim, cmSel, adcCtl};
    logic [11:0] enReg = 12'h004;
    logic [11:0] d1 = 12'h000, d2 = 12'h000, d3 = 12'h000, adc = 12'h000;
    logic [5:0] ti = 6'h00, tq = 6'h00;
    logic [1:0] cm = 2'h0;
    logic [70:0] expQ[$];
    logic [3:0] codes[8] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'hB, 4'hC, 4'hD, 4'hE};
    int bad_count = 0;
    int checked = 0;
    int starts = 0;
    int startSeen = 0;
    event settled;

    always #20 sys_clk = ~sys_clk;

    asmc_host_model host (.serialClk(serialClk), .serialSelN(serialSelN), .serialData(serialData));

    asmc_mode_control dut (.sys_clk(sys_clk), .reset_n(reset_n), .serialClk(serialClk),
        .serialSelN(serialSelN), .serialData(serialData), .txRxPin(txRxPin),
        .rxAdcOn(rxAdcOn), .txDacOn(txDacOn), .busDriveOut(busDriveOut), .clockOn(clockOn),
        .referenceOn(referenceOn), .auxAdcOn(auxAdcOn), .auxDacOn(auxDacOn),
        .auxDacOneValue(dacOne), .auxDacTwoValue(dacTwo), .auxDacThreeValue(dacThree),
        .txITrim(iTrim), .txQTrim(qTrim), .cmLevelSelect(cmSel), .auxAdcControl(adcCtl),
        .auxAdcStart(auxAdcStart));

    task automatic end_of_test();
        if (bad_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [70:0] seen, input logic [70:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // {rx, tx, bus, clk, ref, auxAdc} from the enable word and pin
    function automatic logic [70:0] expect_outputs();
        logic [5:0] p;
        logic [2:0] dac;
        p = {3'b000, 2'b11, ~enReg[9]};
        dac = ~enReg[6:4];
        if (enReg[9] && enReg[2:0] == 3'b000) begin
            p = 6'h00;
            dac = 3'b000;
        end else if (enReg[2:0] == 3'b010) begin
            p = 6'h02;
        end else if (enReg[2:1] != 2'b00) begin
            case (enReg[3:0])
                4'h3: p[5:3] = txRxPin ? 3'b010 : 3'b111;
                4'h4: p[5:3] = txRxPin ? 3'b110 : 3'b101;
                4'h5: p[5:3] = txRxPin ? 3'b010 : 3'b101;
                4'h6: p[5:3] = {2'b11, ~txRxPin};
                4'hB: p[5:3] = 3'b101;
                4'hC: p[5:3] = 3'b010;
                4'hD: p[5:3] = 3'b111;
                4'hE: p[5:3] = 3'b110;
                default: p[5:3] = txRxPin ? 3'b110 : 3'b101;
            endcase
        end
        return {p, dac, d1, d2, d3, ti, tq, cm, adc};
    endfunction : expect_outputs

    task automatic note();
        expQ.push_back(expect_outputs());
        -> settled;
    endtask : note

    task automatic xfer(input logic [3:0] sel, input logic [11:0] pl, input int nbits);
        if (nbits == 16) begin
            case (sel)
                4'h0: enReg = pl;
                4'h1: d1 = pl;
                4'h2: d2 = pl;
                4'h3: d3 = pl;
                4'h4: ti = pl[5:0];
                4'h5: tq = pl[5:0];
                4'h6: cm = pl[1:0];
                4'h7: begin
                    adc = pl;
                    starts++;
                end
                4'h8: enReg[3:0] = pl[3:0];
                default: ;
            endcase
        end
        host.send_word({pl, sel}, nbits);
        note();
    endtask : xfer

    task automatic pin_set(input logic v);
        @(negedge sys_clk);
        txRxPin = v;
        repeat (8) @(negedge sys_clk);
        note();
    endtask : pin_set

    always @(posedge sys_clk) begin
        if (auxAdcStart === 1'b1) begin
            startSeen++;
        end
    end

    initial begin
        forever begin
            @(settled);
            check(seenVec, expQ.pop_front());
        end
    end

    initial begin
        repeat (100000) @(posedge sys_clk);
        bad_count++;
        $display("MISMATCH %0t timeout", $time);
        end_of_test();
    end

    initial begin
        logic [31:0] r;
        void'($urandom(43330));
        reset_n = 1'b0;
        txRxPin = 1'b0;
        repeat (6) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        note();
        foreach (codes[i]) begin
            xfer(4'h0, {8'h00, codes[i]}, 16);
            pin_set(1'b1);
            pin_set(1'b0);
        end
        for (int i = 1; i < 8; i++) begin
            r = $urandom;
            xfer(i[3:0], r[11:0] & {(i != 7), 11'h7FF}, 16);
        end
        for (int j = 0; j < 4; j++) begin
            r = $urandom;
            xfer(4'h6, {r[11:2], j[1:0]}, 16);
        end
        xfer(4'h0, 12'h074, 16);
        xfer(4'h0, 12'h200, 16);
        r = $urandom;
        xfer(4'h2, r[11:0], 16);
        xfer(4'h0, 12'h212, 16);
        pin_set(1'b1);
        xfer(4'h0, 12'h001, 16);
        xfer(4'h0, 12'h204, 16);
        xfer(4'h8, 12'hFF0, 16);
        xfer(4'h8, 12'h00D, 16);
        xfer(4'h9, 12'hABC, 16);
        xfer(4'h1, 12'h555, 15);
        pin_set(1'b0);
        check(71'(startSeen), 71'(starts));
        end_of_test();
    end
endmodule : asmc_mode_control_tb_top
